//--- design/cmf_mailbox_filter_regs.sv
// register logic of two transmit mailboxes, one receive mailbox and filter 0..3 configuration
// assumes a protocol engine that reports attempt results and stores received frames
`timescale 1ns/10ps
`default_nettype none
`include "cmf_params.svh"

module cmf_mailbox_filter_regs
  import cmf_pkg::*;
(
  input  wire logic          i_sys_clk,
  input  wire logic          i_rst,
  input  wire logic [7:0]    i_addr,
  input  wire logic [7:0]    i_wr_data,
  input  wire logic          i_wr_stb,
  input  wire logic          i_rd_stb,
  output logic      [7:0]    o_rd_data,
  input  wire cmf_tx_evt_t   i_tx_evt,
  input  wire cmf_rx_evt_t   i_rx_evt,
  output logic      [1:0]    o_send_request,
  output logic      [1:0]    o_abort_request,
  output cmf_msg_t  [1:0]    o_tx_msg,
  output cmf_filt_cfg_t      o_filt_cfg
);

  cmf_state_t r;
  cmf_state_t n;

  // reserved bits are dropped on store so every read returns them as zero
  function automatic cmf_msg_t msg_clean(input cmf_msg_t m);
    cmf_msg_t c;
    c       = m;
    c.id[0] = m.id[0] & `CMF_M_ID0;
    c.id[3] = m.id[3] & `CMF_M_ID3;
    return c;
  endfunction

  function automatic logic [7:0] msg_rd(input cmf_msg_t m, input logic [3:0] idx);
    logic [3:0] off_id;
    logic [3:0] off_dat;
    logic [7:0] v;
    off_id  = idx - `CMF_IX_ID0;
    off_dat = idx - `CMF_IX_DAT0;
    v       = `CMF_RST_BYTE;
    if (idx == `CMF_IX_DLC)
    begin
      v = {4'h0, m.dlc};
    end
    else if (idx >= `CMF_IX_ID0 && idx <= `CMF_IX_ID3)
    begin
      v = m.id[off_id[1:0]];
    end
    else if (idx >= `CMF_IX_DAT0 && idx <= `CMF_IX_DAT7)
    begin
      v = m.data[off_dat[2:0]];
    end
    return v;
  endfunction

  function automatic cmf_msg_t msg_wr(input cmf_msg_t m, input logic [3:0] idx, input logic [7:0] d);
    logic [3:0] off_id;
    logic [3:0] off_dat;
    cmf_msg_t   c;
    off_id  = idx - `CMF_IX_ID0;
    off_dat = idx - `CMF_IX_DAT0;
    c       = m;
    if (idx == `CMF_IX_DLC)
    begin
      c.dlc = d[3:0];
    end
    else if (idx >= `CMF_IX_ID0 && idx <= `CMF_IX_ID3)
    begin
      c.id[off_id[1:0]] = d;
    end
    else if (idx >= `CMF_IX_DAT0 && idx <= `CMF_IX_DAT7)
    begin
      c.data[off_dat[2:0]] = d;
    end
    return msg_clean(c);
  endfunction

  logic       wr_win;
  logic       tx_page;
  logic       cur_mbx;
  logic [3:0] idx;
  logic [7:0] win_rd;
  logic [7:0] gstat;
  logic [7:0] tprio;
  logic [7:0] rd_val;

  assign wr_win  = i_wr_stb && (i_addr[7:4] == `CMF_A_WIN_HI);
  assign idx     = i_addr[3:0];
  assign cur_mbx = r.page_select_field[0];
  assign tx_page = (r.page_select_field == `CMF_PG_TX0) || (r.page_select_field == `CMF_PG_TX1);

  // global status is built from the mailbox flags, so the two views cannot disagree
  always_comb
  begin
    gstat = `CMF_RST_BYTE;
    tprio = `CMF_RST_BYTE;
    for (int k = 0; k < 2; k++)
    begin
      gstat[`CMF_G_DONE0 + k]  = r.tx_flags[k].request_done_flag;
      gstat[`CMF_G_OK0 + k]    = r.tx_flags[k].tx_success_flag;
      tprio[`CMF_P_EMPTY0 + k] = !r.tx_flags[k].send_request;
    end
  end

  always_comb
  begin
    win_rd = `CMF_RST_BYTE;
    unique case (r.page_select_field)
      `CMF_PG_TX0, `CMF_PG_TX1:
      begin
        if (idx == `CMF_IX_CSR)
        begin
          win_rd = {2'b00, r.tx_flags[cur_mbx]};
        end
        else
        begin
          win_rd = msg_rd(r.tx_msg[cur_mbx], idx);
        end
      end
      `CMF_PG_RX:
      begin
        if (idx == `CMF_IX_CSR)
        begin
          win_rd = r.fmi;
        end
        else
        begin
          win_rd = msg_rd(r.rx_msg, idx);
        end
      end
      `CMF_PG_CFG:
      begin
        if (idx == `CMF_IX_FCFG0)
        begin
          win_rd = r.filt.pair_a;
        end
        else if (idx == `CMF_IX_FCFG1)
        begin
          win_rd = r.filt.pair_b;
        end
      end
      // filter banks and the reserved page lie outside this block and read zero
      `CMF_PG_FLT01, `CMF_PG_FLT23, `CMF_PG_FLT45, `CMF_PG_RSVD:
      begin
        win_rd = `CMF_RST_BYTE;
      end
    endcase
  end

  always_comb
  begin
    if (i_addr[7:4] == `CMF_A_WIN_HI)
    begin
      rd_val = win_rd;
    end
    else if (i_addr == `CMF_A_PAGE)
    begin
      rd_val = {5'h00, r.page_select_field};
    end
    else if (i_addr == `CMF_A_GSTAT)
    begin
      rd_val = gstat;
    end
    else if (i_addr == `CMF_A_TPRIO)
    begin
      rd_val = tprio;
    end
    else
    begin
      rd_val = `CMF_RST_BYTE;
    end
  end

  logic [1:0] clr_done;
  logic       evt_ok;
  logic       evt_fail;
  logic       evt_empty;

  always_comb
  begin
    n        = r;
    clr_done = 2'b00;
    evt_ok   = 1'b0;
    evt_fail = 1'b0;
    evt_empty = 1'b0;
    n.rd_data = i_rd_stb ? rd_val : `CMF_RST_BYTE;

    if (wr_win && tx_page)
    begin
      if (idx == `CMF_IX_CSR)
      begin
        if (i_wr_data[`CMF_B_SEND_REQUEST])
        begin
          n.tx_flags[cur_mbx].send_request = 1'b1;
          clr_done[cur_mbx]                = 1'b1;
        end
        // abort on an idle mailbox would leave a stale flag, so it is dropped
        if (i_wr_data[`CMF_B_ABORT_REQUEST] && r.tx_flags[cur_mbx].send_request)
        begin
          n.tx_flags[cur_mbx].abort_request = 1'b1;
        end
        if (i_wr_data[`CMF_B_REQUEST_DONE_FLAG])
        begin
          clr_done[cur_mbx] = 1'b1;
        end
      end
      else if (!r.tx_flags[cur_mbx].send_request)
      begin
        n.tx_msg[cur_mbx] = msg_wr(r.tx_msg[cur_mbx], idx, i_wr_data);
      end
    end

    if (wr_win && (r.page_select_field == `CMF_PG_CFG))
    begin
      if (idx == `CMF_IX_FCFG0)
      begin
        n.filt.pair_a = i_wr_data & `CMF_M_FCFG;
      end
      else if (idx == `CMF_IX_FCFG1)
      begin
        n.filt.pair_b = i_wr_data & `CMF_M_FCFG;
      end
    end

    if (i_wr_stb && (i_addr == `CMF_A_PAGE))
    begin
      n.page_select_field = i_wr_data[2:0];
    end
    if (i_wr_stb && (i_addr == `CMF_A_GSTAT))
    begin
      clr_done = clr_done | i_wr_data[`CMF_G_DONE0 +: 2];
    end

    for (int k = 0; k < 2; k++)
    begin
      if (clr_done[k])
      begin
        n.tx_flags[k].request_done_flag = 1'b0;
        n.tx_flags[k].tx_success_flag   = 1'b0;
        n.tx_flags[k].arb_lost_flag     = 1'b0;
        n.tx_flags[k].tx_error_flag     = 1'b0;
      end
    end

    // hardware result comes last so a same-cycle software clear never hides it
    if (i_tx_evt.valid && r.tx_flags[i_tx_evt.mbx].send_request)
    begin
      evt_ok    = (i_tx_evt.res == CMF_RES_OK);
      evt_fail  = (i_tx_evt.res == CMF_RES_ARB) || (i_tx_evt.res == CMF_RES_ERR);
      evt_empty = evt_ok || (i_tx_evt.res == CMF_RES_ABORT) || r.tx_flags[i_tx_evt.mbx].abort_request;
      n.tx_flags[i_tx_evt.mbx].tx_error_flag   = (i_tx_evt.res == CMF_RES_ERR);
      n.tx_flags[i_tx_evt.mbx].arb_lost_flag   = (i_tx_evt.res == CMF_RES_ARB);
      n.tx_flags[i_tx_evt.mbx].tx_success_flag = evt_ok && !evt_fail;
      if (evt_empty)
      begin
        n.tx_flags[i_tx_evt.mbx].send_request      = 1'b0;
        n.tx_flags[i_tx_evt.mbx].abort_request     = 1'b0;
        n.tx_flags[i_tx_evt.mbx].request_done_flag = 1'b1;
      end
    end

    if (i_rx_evt.valid)
    begin
      n.rx_msg = msg_clean(i_rx_evt.msg);
      n.fmi    = i_rx_evt.match_index_field;
    end
  end

  // payload and identifier have no documented reset value; zero is used for simplicity
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign o_rd_data       = r.rd_data;
  assign o_send_request  = {r.tx_flags[1].send_request, r.tx_flags[0].send_request};
  assign o_abort_request = {r.tx_flags[1].abort_request, r.tx_flags[0].abort_request};
  assign o_tx_msg        = r.tx_msg;
  assign o_filt_cfg      = r.filt;

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  logic wr_csr0;
  logic wr_pg0;
  assign wr_csr0 = wr_win && (idx == `CMF_IX_CSR) && (r.page_select_field == `CMF_PG_TX0);
  assign wr_pg0  = wr_win && (r.page_select_field == `CMF_PG_TX0);

  sequence s_evt0(cmf_tx_result_t res);
    i_tx_evt.valid && !i_tx_evt.mbx && (i_tx_evt.res == res) && r.tx_flags[0].send_request;
  endsequence

  sequence s_rd_gstat;
    i_rd_stb && (i_addr == `CMF_A_GSTAT);
  endsequence

  AST_TX_ERROR_FLAG_SET: assert property (s_evt0(CMF_RES_ERR) |=>
      r.tx_flags[0].tx_error_flag && !r.tx_flags[0].tx_success_flag)
    else $error("error result did not set the transmit error flag");
  AST_ARB_LOST_FLAG_SET: assert property (s_evt0(CMF_RES_ARB) |=>
      r.tx_flags[0].arb_lost_flag && !r.tx_flags[0].tx_error_flag)
    else $error("arbitration loss did not set its flag");
  AST_OK_SET: assert property (s_evt0(CMF_RES_OK) |=>
      r.tx_flags[0].tx_success_flag && r.tx_flags[0].request_done_flag && !r.tx_flags[0].send_request)
    else $error("success did not complete the mailbox");
  AST_ABORT_DONE: assert property (s_evt0(CMF_RES_ABORT) |=>
      r.tx_flags[0].request_done_flag && !r.tx_flags[0].send_request && !r.tx_flags[0].abort_request)
    else $error("abort result did not empty the mailbox");
  AST_GLOBAL_MIRROR: assert property (s_rd_gstat |=>
      (o_rd_data[`CMF_G_OK0] == $past(r.tx_flags[0].tx_success_flag))
      && (o_rd_data[`CMF_G_DONE0] == $past(r.tx_flags[0].request_done_flag)))
    else $error("global status does not mirror mailbox 0");
  AST_DONE_CLR: assert property (wr_csr0 && i_wr_data[`CMF_B_REQUEST_DONE_FLAG] && !i_tx_evt.valid |=>
      !r.tx_flags[0].request_done_flag && !r.tx_flags[0].tx_success_flag
      && !r.tx_flags[0].arb_lost_flag && !r.tx_flags[0].tx_error_flag)
    else $error("clearing done left status bits set");
  AST_REQ_CLRS_DONE: assert property (wr_csr0 && i_wr_data[`CMF_B_SEND_REQUEST]
      && !r.tx_flags[0].send_request |=> r.tx_flags[0].send_request && !r.tx_flags[0].request_done_flag)
    else $error("send request did not clear done");
  AST_ABORT_IGN: assert property (wr_csr0 && i_wr_data[`CMF_B_ABORT_REQUEST] && !r.tx_flags[0].send_request
      |=> !r.tx_flags[0].abort_request)
    else $error("abort accepted on an idle mailbox");
  AST_SEND_REQUEST_HOLD: assert property (r.tx_flags[0].send_request && wr_csr0 && !i_tx_evt.valid |=>
      r.tx_flags[0].send_request)
    else $error("software cleared the send request");
  AST_DLC_PROT: assert property (r.tx_flags[0].send_request && wr_pg0 && (idx == `CMF_IX_DLC) |=>
      $stable(r.tx_msg[0].dlc))
    else $error("length code written while mailbox busy");
  AST_DATA_PROT: assert property (r.tx_flags[0].send_request && wr_pg0 && (idx >= `CMF_IX_DAT0) |=>
      $stable(r.tx_msg[0].data))
    else $error("payload written while mailbox busy");
  AST_RX_RO: assert property (wr_win && (r.page_select_field == `CMF_PG_RX) && !i_rx_evt.valid |=>
      $stable(r.rx_msg) && $stable(r.fmi))
    else $error("receive mailbox was written by software");
  AST_RSVD_ZERO: assert property (i_rd_stb && (i_addr[7:4] == `CMF_A_WIN_HI)
      && (idx == `CMF_IX_CSR) && tx_page |=> o_rd_data[7:6] == 2'b00)
    else $error("reserved status bits read nonzero");
  AST_FCFG_RSVD: assert property (wr_win && (r.page_select_field == `CMF_PG_CFG)
      && (idx == `CMF_IX_FCFG0) |=> (r.filt.pair_a & ~`CMF_M_FCFG) == 8'h00)
    else $error("reserved filter configuration bits were stored");
  AST_PAGE_RSVD: assert property (i_rd_stb && (i_addr == `CMF_A_PAGE) |=> o_rd_data[7:3] == 5'h00)
    else $error("page select read back reserved bits");

endmodule // cmf_mailbox_filter_regs

`default_nettype wire

//--- design/cmf_params.svh
// constants of the can mailbox and filter-configuration register block
// assumes byte-wide register port with 8-bit addresses and a 16-byte paged window
`ifndef CMF_PARAMS_SVH
`define CMF_PARAMS_SVH

`define CMF_A_WIN_HI   4'h7
`define CMF_A_PAGE     8'h6F
`define CMF_A_GSTAT    8'h6E
`define CMF_A_TPRIO    8'h6D

`define CMF_IX_CSR     4'h0
`define CMF_IX_DLC     4'h1
`define CMF_IX_ID0     4'h2
`define CMF_IX_ID3     4'h5
`define CMF_IX_DAT0    4'h6
`define CMF_IX_DAT7    4'hD
`define CMF_IX_FCFG0   4'hA
`define CMF_IX_FCFG1   4'hB

`define CMF_PG_TX0     3'h0
`define CMF_PG_TX1     3'h1
`define CMF_PG_FLT01   3'h2
`define CMF_PG_FLT23   3'h3
`define CMF_PG_FLT45   3'h4
`define CMF_PG_RSVD    3'h5
`define CMF_PG_CFG     3'h6
`define CMF_PG_RX      3'h7

`define CMF_B_TX_ERROR_FLAG     5
`define CMF_B_ARB_LOST_FLAG     4
`define CMF_B_TX_SUCCESS_FLAG     3
`define CMF_B_REQUEST_DONE_FLAG     2
`define CMF_B_ABORT_REQUEST     1
`define CMF_B_SEND_REQUEST     0
`define CMF_B_IDE      6
`define CMF_B_RTR      5

`define CMF_G_DONE0    0
`define CMF_G_OK0      4
`define CMF_P_EMPTY0   2

`define CMF_M_ID0      8'h7F
`define CMF_M_ID3      8'hFE
`define CMF_M_DLC      8'h0F
`define CMF_M_FCFG     8'h77
`define CMF_M_PAGE     8'h07

`define CMF_RST_BYTE   8'h00

`endif

//--- design/cmf_pkg.sv
// types of the can mailbox and filter-configuration register block
// assumes cmf_params.svh supplies all offsets and bit positions
package cmf_pkg;

  // id[0] is the first identifier byte, data[0] the first payload byte
  typedef struct packed {
    logic [7:0][7:0] data;
    logic [3:0]      dlc;
    logic [3:0][7:0] id;
  } cmf_msg_t;

  // field order equals bit order 5..0 of the control-status byte
  typedef struct packed {
    logic tx_error_flag;
    logic arb_lost_flag;
    logic tx_success_flag;
    logic request_done_flag;
    logic abort_request;
    logic send_request;
  } cmf_tx_flags_t;

  typedef enum logic [1:0] {
    CMF_RES_OK    = 2'h0,
    CMF_RES_ARB   = 2'h1,
    CMF_RES_ERR   = 2'h3,
    CMF_RES_ABORT = 2'h2
  } cmf_tx_result_t;

  typedef struct packed {
    logic           valid;
    logic           mbx;
    cmf_tx_result_t res;
  } cmf_tx_evt_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] match_index_field;
    cmf_msg_t   msg;
  } cmf_rx_evt_t;

  typedef struct packed {
    logic [7:0] pair_b;
    logic [7:0] pair_a;
  } cmf_filt_cfg_t;

  typedef struct packed {
    cmf_msg_t      [1:0] tx_msg;
    cmf_tx_flags_t [1:0] tx_flags;
    cmf_msg_t            rx_msg;
    logic          [7:0] fmi;
    logic          [2:0] page_select_field;
    cmf_filt_cfg_t       filt;
    logic          [7:0] rd_data;
  } cmf_state_t;

endpackage

//--- tb/cmf_engine_model.sv
// protocol engine stand-in: reports transmit attempt results and stores received frames
// assumes the bench commands each event; drives on the rising edge of i_sys_clk
`timescale 1ns/10ps
`default_nettype none

module cmf_engine_model
  import cmf_pkg::*;
(
  input  wire logic           i_sys_clk,
  input  wire logic           i_rst,
  input  wire logic [1:0]     i_pending,
  input  wire logic           i_tx_go,
  input  wire logic           i_tx_mbx,
  input  wire cmf_tx_result_t i_tx_res,
  input  wire logic           i_rx_go,
  input  wire logic [7:0]     i_rx_fmi,
  input  wire cmf_msg_t       i_rx_msg,
  output cmf_tx_evt_t         o_tx_evt,
  output cmf_rx_evt_t         o_rx_evt
);
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_tx_evt <= '0;
      o_rx_evt <= '0;
    end
    else
    begin
      // an engine only attempts a mailbox that asked to send, so no stray results
      o_tx_evt <= '{valid: i_tx_go & i_pending[i_tx_mbx], mbx: i_tx_mbx, res: i_tx_res};
      o_rx_evt <= '{valid: i_rx_go, match_index_field: i_rx_fmi, msg: i_rx_msg};
    end
  end
endmodule // cmf_engine_model

`default_nettype wire

//--- tb/cmf_mailbox_filter_regs_bench.sv
// self-checking bench of the mailbox and filter-configuration registers
// assumes the engine model above and the register map of cmf_params.svh
`timescale 1ns/10ps
`default_nettype none
`include "cmf_params.svh"

module cmf_mailbox_filter_regs_bench
  import cmf_pkg::*;
;
  logic           i_sys_clk = 1'b0;
  logic           i_rst = 1'b1;
  logic [7:0]     i_addr = 8'h00;
  logic [7:0]     i_wr_data = 8'h00;
  logic           i_wr_stb = 1'b0;
  logic           i_rd_stb = 1'b0;
  logic [7:0]     o_rd_data;
  cmf_tx_evt_t    tx_evt;
  cmf_rx_evt_t    rx_evt;
  logic [1:0]     o_send_request;
  logic [1:0]     o_abort_request;
  cmf_msg_t [1:0] o_tx_msg;
  cmf_filt_cfg_t  o_filt_cfg;
  logic           tx_go = 1'b0;
  logic           tx_mbx = 1'b0;
  cmf_tx_result_t tx_res = CMF_RES_OK;
  logic           rx_go = 1'b0;
  cmf_msg_t       rx_msg = '0;
  int             n_fail = 0;
  int             n_compared = 0;
  logic [22:0]    rows [9];
  logic [7:0]     d;

  initial
  begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  cmf_mailbox_filter_regs u_cmf_mailbox_filter_regs (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .i_tx_evt(tx_evt),
    .i_rx_evt(rx_evt), .o_send_request(o_send_request), .o_abort_request(o_abort_request),
    .o_tx_msg(o_tx_msg), .o_filt_cfg(o_filt_cfg));

  cmf_engine_model u_cmf_engine_model (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_pending(o_send_request),
    .i_tx_go(tx_go), .i_tx_mbx(tx_mbx), .i_tx_res(tx_res), .i_rx_go(rx_go), .i_rx_fmi(8'h03),
    .i_rx_msg(rx_msg), .o_tx_evt(tx_evt), .o_rx_evt(rx_evt));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wr_data <= v;
    i_wr_stb <= 1'b1;
    @(posedge i_sys_clk);
    i_wr_stb <= 1'b0;
    #1; // let the register update settle before callers look at outputs
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_sys_clk);
    i_rd_stb <= 1'b0;
    #1 v = o_rd_data;
  endtask

  task automatic fire(input logic m, input cmf_tx_result_t r);
    @(posedge i_sys_clk);
    tx_mbx <= m;
    tx_res <= r;
    tx_go <= 1'b1;
    @(posedge i_sys_clk);
    tx_go <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
  endtask

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_fail++;
    close_out();
  end

  initial
  begin
    // page, index, write value, value read back
    // length writes keep bit 7 clear; filter rows stand for init-mode setup, no bank byte touched
    rows = '{{3'h0, 4'h1, 8'h7F, 8'h0F}, {3'h0, 4'h2, 8'hFF, 8'h7F}, {3'h0, 4'h3, 8'hA5, 8'hA5},
             {3'h0, 4'h5, 8'hFF, 8'hFE}, {3'h1, 4'hD, 8'h3C, 8'h3C}, {3'h6, 4'hA, 8'hFF, 8'h77},
             {3'h6, 4'hB, 8'h5A, 8'h52}, {3'h5, 4'h0, 8'hFF, 8'h00}, {3'h7, 4'h1, 8'h7F, 8'h00}};
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(8'h70, d); chk(d, 8'h00);
    rd(8'h6D, d); chk(d, 8'h0C);
    wr(8'h6F, 8'h07);
    rd(8'h70, d); chk(d, 8'h00);
    chk(o_filt_cfg.pair_b, 8'h00);
    $display("reset values done");
    foreach (rows[i])
    begin
      wr(8'h6F, {5'h00, rows[i][22:20]});
      wr({4'h7, rows[i][19:16]}, rows[i][15:8]);
      rd({4'h7, rows[i][19:16]}, d);
      chk(d, rows[i][7:0]);
    end
    chk(o_filt_cfg.pair_a, 8'h77);
    chk(o_tx_msg[1].data[7], 8'h3C);
    chk(o_tx_msg[0].id[0], 8'h7F);
    $display("table done");
    wr(8'h6F, 8'h00);
    wr(8'h70, 8'h01);
    chk({6'h00, o_send_request}, 8'h01);
    wr(8'h71, 8'h03);
    rd(8'h71, d); chk(d, 8'h0F);
    wr(8'h76, 8'h55);
    rd(8'h76, d); chk(d, 8'h00);
    fire(1'b0, CMF_RES_ARB);
    rd(8'h70, d); chk(d, 8'h11);
    fire(1'b0, CMF_RES_ERR);
    wr(8'h70, 8'h00);
    rd(8'h70, d); chk(d, 8'h21);
    fire(1'b0, CMF_RES_OK);
    rd(8'h70, d); chk(d, 8'h0C);
    rd(8'h6E, d); chk(d, 8'h11);
    wr(8'h70, 8'h04);
    rd(8'h70, d); chk(d, 8'h00);
    rd(8'h6E, d); chk(d, 8'h00);
    $display("transmit status done");
    wr(8'h70, 8'h02);
    rd(8'h70, d); chk(d, 8'h00);
    wr(8'h70, 8'h01);
    wr(8'h70, 8'h02);
    rd(8'h70, d); chk(d, 8'h03);
    chk({6'h00, o_abort_request}, 8'h01);
    fire(1'b0, CMF_RES_ABORT);
    rd(8'h70, d); chk(d, 8'h04);
    wr(8'h70, 8'h01);
    rd(8'h70, d); chk(d, 8'h01);
    $display("abort done");
    wr(8'h6F, 8'h01);
    wr(8'h70, 8'h01);
    fire(1'b1, CMF_RES_OK);
    rd(8'h6E, d); chk(d, 8'h22);
    rd(8'h6D, d); chk(d, 8'h08);
    rd(8'h70, d); chk(d, 8'h0C);
    $display("second mailbox done");
    @(posedge i_sys_clk);
    rx_msg <= '{data: '0, dlc: 4'h5, id: '0};
    rx_go <= 1'b1;
    @(posedge i_sys_clk);
    rx_go <= 1'b0;
    wr(8'h6F, 8'h07);
    rd(8'h70, d); chk(d, 8'h03);
    wr(8'h71, 8'h0A);
    rd(8'h71, d); chk(d, 8'h05);
    $display("receive done");
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(8'h6F, d); chk(d, 8'h00);
    rd(8'h70, d); chk(d, 8'h00);
    rd(8'h6D, d); chk(d, 8'h0C);
    chk(o_filt_cfg.pair_a, 8'h00);
    chk({6'h00, o_send_request}, 8'h00);
    $display("reset again done");
    close_out();
  end
endmodule // cmf_mailbox_filter_regs_bench

`default_nettype wire
